// ---- rtl/fmsc_cmd.v ----
// Statistics command handler of a fieldbus master, APB programmed
//
// Local design decisions: register access over APB and the register addresses.
`include "fmsc_defs.vh"

module fmsc_cmd #(
  parameter [7:0] FW_MAJOR = 8'h01,
  parameter [7:0] FW_MINOR = 8'h00
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        ce,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire [9:0]  evt_pin,
  input  wire        is_master,
  input  wire [7:0]  global_state,
  input  wire [7:0]  shared_memory_state,
  input  wire        err_report,
  input  wire        err_by_master,
  input  wire [6:0]  err_station,
  input  wire [7:0]  err_code,
  input  wire [15:0] slaves_detected,
  input  wire [15:0] slaves_set_up,
  input  wire [15:0] slaves_exchanging,
  input  wire [15:0] exchange_time_ms,
  output reg         mem_we,
  output reg         mem_is_status,
  output reg  [15:0] mem_type,
  output reg  [15:0] mem_addr,
  output reg  [15:0] mem_data,
  output reg         busy
);
  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_SEND = 2'b01;
  localparam [1:0] ST_STAT = 2'b10;

  ////////////////////////////////////////////////////////////////////////////
  // Event pins

  wire [`FMSC_NCNT-1:0] evt_p;

  fmsc_sync #(
    .W (`FMSC_NCNT)
  ) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .pin_in  (evt_pin),
    .rise_p  (evt_p)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Registers and state

  reg  [15:0] len_q;
  reg  [15:0] wait_q;
  reg  [15:0] stat_type_q;
  reg  [15:0] stat_addr_q;
  reg  [15:0] cmd_q;
  reg  [15:0] rsp_type_q;
  reg  [15:0] rsp_ofs_q;
  reg  [15:0] rsp_size_q;
  reg         done_q;
  reg  [15:0] last_st_q;
  reg  [1:0]  state_q;
  reg  [4:0]  idx_q;
  reg  [4:0]  nwords_q;
  reg  [15:0] st_code_q;
  reg         clr_cnt_q;
  reg  [7:0]  err_src_q;
  reg  [7:0]  err_evt_q;
  reg  [15:0] rply_q [0:19];
  wire [16*`FMSC_NCNT-1:0] cnt_w;

  wire        wr_en   = psel & penable & pready & pwrite;
  wire        setup   = psel & ~penable;
  wire [5:0]  widx    = paddr[7:2];
  wire        rply_hit = (paddr[1:0] == 2'b00) && (widx >= `FMSC_W_RPLY_FIRST) &&
                         (widx <= `FMSC_W_RPLY_LAST);
  wire [5:0]  rply_i6 = widx - `FMSC_W_RPLY_FIRST;
  wire [4:0]  rply_i  = rply_i6[4:0];
  wire        go      = wr_en && (paddr == `FMSC_A_CTRL) && pwdata[`FMSC_B_GO];
  wire        done_clr = wr_en && (paddr == `FMSC_A_CTRL) && pwdata[`FMSC_B_DONE_CLR];

  ////////////////////////////////////////////////////////////////////////////
  // Statistics counters

  genvar k;
  generate
    for (k = 0; k < `FMSC_NCNT; k = k + 1) begin : g_cnt
      reg [15:0] c_q;
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          c_q <= 16'h0000;
        end else if (ce) begin
          // An event landing on the clear cycle is kept as the first count
          if (clr_cnt_q) begin
            c_q <= {15'h0000, evt_p[k]};
          end else if (evt_p[k]) begin
            c_q <= c_q + 16'h0001;
          end
        end
      end
      assign cnt_w[16*k +: 16] = c_q;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Last error latch

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_src_q <= 8'h00;
      err_evt_q <= 8'h00;
    end else if (ce && err_report) begin
      if (err_by_master) begin
        err_src_q <= `FMSC_SRC_MASTER;
      end else begin
        err_src_q <= {1'b0, err_station};
      end
      err_evt_q <= err_code;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: one wait-free access phase after setup

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (ce) begin
      pready  <= setup;
      pslverr <= 1'b0;
      if (setup) begin
        prdata <= 32'h0000_0000;
        if (rply_hit) begin
          if (!pwrite) begin
            prdata <= {16'h0000, rply_q[rply_i]};
          end else begin
            pslverr <= 1'b1;
          end
        end else if (paddr == `FMSC_A_CTRL) begin
          prdata <= 32'h0000_0000;
        end else if (paddr == `FMSC_A_STATUS) begin
          prdata <= {last_st_q, 14'h0000, done_q, busy};
        end else if (paddr == `FMSC_A_LEN) begin
          prdata <= {16'h0000, len_q};
        end else if (paddr == `FMSC_A_WAIT) begin
          prdata <= {16'h0000, wait_q};
        end else if (paddr == `FMSC_A_STAT_TYPE) begin
          prdata <= {16'h0000, stat_type_q};
        end else if (paddr == `FMSC_A_STAT_ADDR) begin
          prdata <= {16'h0000, stat_addr_q};
        end else if (paddr == `FMSC_A_CMD) begin
          prdata <= {16'h0000, cmd_q};
        end else if (paddr == `FMSC_A_RSP_TYPE) begin
          prdata <= {16'h0000, rsp_type_q};
        end else if (paddr == `FMSC_A_RSP_OFS) begin
          prdata <= {16'h0000, rsp_ofs_q};
        end else if (paddr == `FMSC_A_RSP_SIZE) begin
          prdata <= {16'h0000, rsp_size_q};
        end else begin
          pslverr <= 1'b1;
        end
      end
    end
  end

  // Command block words are frozen while a request runs
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      len_q       <= 16'h0000;
      wait_q      <= 16'h0000;
      stat_type_q <= 16'h0000;
      stat_addr_q <= 16'h0000;
      cmd_q       <= 16'h0000;
      rsp_type_q  <= 16'h0000;
      rsp_ofs_q   <= 16'h0000;
      rsp_size_q  <= 16'h0000;
    end else if (ce && wr_en && !busy) begin
      if (paddr == `FMSC_A_LEN) begin
        len_q <= pwdata[15:0];
      end else if (paddr == `FMSC_A_WAIT) begin
        wait_q <= pwdata[15:0];
      end else if (paddr == `FMSC_A_STAT_TYPE) begin
        stat_type_q <= pwdata[15:0];
      end else if (paddr == `FMSC_A_STAT_ADDR) begin
        stat_addr_q <= pwdata[15:0];
      end else if (paddr == `FMSC_A_CMD) begin
        cmd_q <= pwdata[15:0];
      end else if (paddr == `FMSC_A_RSP_TYPE) begin
        rsp_type_q <= pwdata[15:0];
      end else if (paddr == `FMSC_A_RSP_OFS) begin
        rsp_ofs_q <= pwdata[15:0];
      end else if (paddr == `FMSC_A_RSP_SIZE) begin
        rsp_size_q <= pwdata[15:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command sequencer

  // Only no-wait requests are served
  wire wait_ok  = (wait_q == `FMSC_WAIT_NONE);
  wire hdr_ok   = wait_ok && (rsp_size_q >= {11'h000, `FMSC_LEN_HEADER});
  wire clr_size = (rsp_size_q <= {11'h000, `FMSC_LEN_CLEAR});

  integer j;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q   <= ST_IDLE;
      busy      <= 1'b0;
      done_q    <= 1'b0;
      last_st_q <= 16'h0000;
      st_code_q <= 16'h0000;
      idx_q     <= 5'h00;
      nwords_q  <= 5'h00;
      clr_cnt_q <= 1'b0;
      mem_we        <= 1'b0;
      mem_is_status <= 1'b0;
      mem_type      <= 16'h0000;
      mem_addr      <= 16'h0000;
      mem_data      <= 16'h0000;
      for (j = 0; j < `FMSC_LEN_HEADER; j = j + 1) begin
        rply_q[j] <= 16'h0000;
      end
    end else if (ce) begin
      clr_cnt_q <= 1'b0;
      mem_we    <= 1'b0;
      // Completion sets done in the same cycle a clear would drop it
      if (done_clr) begin
        done_q <= 1'b0;
      end
      case (state_q)
        ST_IDLE: begin
          if (go) begin
            busy    <= 1'b1;
            idx_q   <= 5'h00;
            state_q <= ST_SEND;
            if (cmd_q == `FMSC_CMD_HEADER && hdr_ok) begin
              rply_q[0]  <= `FMSC_CMD_HEADER;
              rply_q[1]  <= is_master ? `FMSC_ROLE_MASTER : `FMSC_ROLE_SLAVE;
              rply_q[2]  <= {FW_MAJOR, FW_MINOR};
              rply_q[3]  <= {shared_memory_state, global_state};
              rply_q[4]  <= {(err_src_q != 8'h00) ? err_evt_q : 8'h00, err_src_q};
              rply_q[5]  <= cnt_w[16*`FMSC_E_BUS_FAULT +: 16];
              rply_q[6]  <= cnt_w[16*`FMSC_E_REJECTED +: 16];
              rply_q[7]  <= cnt_w[16*`FMSC_E_DIAG +: 16];
              rply_q[8]  <= cnt_w[16*`FMSC_E_GLOBAL +: 16];
              rply_q[9]  <= cnt_w[16*`FMSC_E_EXCH +: 16];
              rply_q[10] <= cnt_w[16*`FMSC_E_EXCH_POS +: 16];
              rply_q[11] <= cnt_w[16*`FMSC_E_EXCH_NEG +: 16];
              rply_q[12] <= cnt_w[16*`FMSC_E_ACT +: 16];
              rply_q[13] <= cnt_w[16*`FMSC_E_ALL_POS +: 16];
              rply_q[14] <= cnt_w[16*`FMSC_E_ALL_NEG +: 16];
              rply_q[15] <= slaves_detected;
              rply_q[16] <= slaves_set_up;
              rply_q[17] <= slaves_exchanging;
              rply_q[18] <= exchange_time_ms;
              rply_q[19] <= 16'h0000;
              nwords_q   <= `FMSC_LEN_HEADER;
              st_code_q  <= `FMSC_ST_OK;
            end else if (cmd_q == `FMSC_CMD_CLEAR && wait_ok) begin
              rply_q[0] <= `FMSC_CMD_CLEAR;
              nwords_q  <= `FMSC_LEN_CLEAR;
              if (clr_size) begin
                clr_cnt_q <= 1'b1;
                rply_q[1] <= `FMSC_CLR_OK;
                st_code_q <= `FMSC_ST_OK;
              end else begin
                rply_q[1] <= `FMSC_CLR_FAIL;
                st_code_q <= `FMSC_ST_FAIL;
              end
            end else begin
              // Unknown command or bad block: status only, no reply words
              nwords_q  <= 5'h00;
              st_code_q <= `FMSC_ST_FAIL;
            end
          end
        end
        ST_SEND: begin
          if (idx_q == nwords_q) begin
            state_q <= ST_STAT;
          end else begin
            mem_we        <= 1'b1;
            mem_is_status <= 1'b0;
            mem_type      <= rsp_type_q;
            mem_addr      <= rsp_ofs_q + {11'h000, idx_q};
            mem_data      <= rply_q[idx_q];
            idx_q         <= idx_q + 5'h01;
          end
        end
        ST_STAT: begin
          mem_we        <= 1'b1;
          mem_is_status <= 1'b1;
          mem_type      <= stat_type_q;
          mem_addr      <= stat_addr_q + 16'h0001;
          mem_data      <= st_code_q;
          last_st_q     <= st_code_q;
          done_q        <= 1'b1;
          busy          <= 1'b0;
          state_q       <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
          busy    <= 1'b0;
        end
      endcase
    end
  end
endmodule // fmsc_cmd

// ---- rtl/fmsc_defs.vh ----
// Constants for the fieldbus master statistics command handler
`ifndef FMSC_DEFS_VH
`define FMSC_DEFS_VH

// APB byte offsets
`define FMSC_A_CTRL       8'h00
`define FMSC_A_STATUS     8'h04
`define FMSC_A_LEN        8'h08
`define FMSC_A_WAIT       8'h0C
`define FMSC_A_STAT_TYPE  8'h10
`define FMSC_A_STAT_ADDR  8'h14
`define FMSC_A_CMD        8'h18
`define FMSC_A_RSP_TYPE   8'h1C
`define FMSC_A_RSP_OFS    8'h20
`define FMSC_A_RSP_SIZE   8'h24
// Reply words 1..20 sit at word index 16..35 (byte 0x40..0x8C)
`define FMSC_W_RPLY_FIRST 6'h10
`define FMSC_W_RPLY_LAST  6'h23

// Control and status bit positions
`define FMSC_B_GO         0
`define FMSC_B_DONE_CLR   1
`define FMSC_B_BUSY       0
`define FMSC_B_DONE       1

// Command codes and reply shapes
`define FMSC_CMD_HEADER   16'h0005
`define FMSC_CMD_CLEAR    16'h0006
`define FMSC_LEN_HEADER   5'h14
`define FMSC_LEN_CLEAR    5'h02
`define FMSC_WAIT_NONE    16'h0000
`define FMSC_ROLE_MASTER  16'h0002
`define FMSC_ROLE_SLAVE   16'h0001
`define FMSC_CLR_OK       16'h0001
`define FMSC_CLR_FAIL     16'h0000
`define FMSC_SRC_MASTER   8'hFF

// Request status word values
`define FMSC_ST_OK        16'h0001
`define FMSC_ST_FAIL      16'h0002

// Statistics counter slots
`define FMSC_NCNT         10
`define FMSC_E_BUS_FAULT  0
`define FMSC_E_REJECTED   1
`define FMSC_E_DIAG       2
`define FMSC_E_GLOBAL     3
`define FMSC_E_EXCH       4
`define FMSC_E_EXCH_POS   5
`define FMSC_E_EXCH_NEG   6
`define FMSC_E_ACT        7
`define FMSC_E_ALL_POS    8
`define FMSC_E_ALL_NEG    9

`endif

// ---- rtl/fmsc_sync.v ----
// Three-stage pin synchroniser with rising-edge pulse, one per bit
module fmsc_sync #(
  parameter W = 10
) (
  input  wire         pclk,
  input  wire         presetn,
  input  wire         ce,
  input  wire [W-1:0] pin_in,
  output wire [W-1:0] rise_p
);
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      reg s1_q;
      reg s2_q;
      reg s3_q;
      reg p_q;
      reg s3_prev_q;
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
          s3_q <= 1'b0;
          p_q  <= 1'b0;
        end else if (ce) begin
          s1_q <= pin_in[i];
          s2_q <= s1_q;
          s3_q <= s2_q;
          // Edge counts only once stages two and three agree on the new level
          p_q  <= s2_q & s3_q & ~p_q & ~s3_prev_q;
        end
      end
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          s3_prev_q <= 1'b0;
        end else if (ce) begin
          s3_prev_q <= s3_q;
        end
      end
      assign rise_p[i] = p_q;
    end
  endgenerate
endmodule // fmsc_sync

// ---- testbench/fmsc_cmd_props.sv ----
// Port-level assertions for the statistics command handler
`include "fmsc_defs.vh"
module fmsc_cmd_props (
  input wire        pclk,
  input wire        presetn,
  input wire        ce,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire        pready,
  input wire        pslverr,
  input wire        is_master,
  input wire        mem_we,
  input wire        mem_is_status,
  input wire [15:0] mem_addr,
  input wire [15:0] mem_data,
  input wire        busy
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] cmd_q, wt_q, sz_q, sa_q, of_q;
  wire         wr_c = psel & penable & pready & pwrite & ce;
  wire         go   = wr_c & (paddr == `FMSC_A_CTRL) & pwdata[`FMSC_B_GO] & !busy;
  wire         hdr  = go && cmd_q == `FMSC_CMD_HEADER && wt_q == 16'h0000 && sz_q >= 16'h0014;
  wire         clr  = go && cmd_q == `FMSC_CMD_CLEAR && wt_q == 16'h0000;
  // Shadow of the block words; the block ignores them while busy
  always @(posedge pclk or negedge presetn)
    if (!presetn) begin
      cmd_q <= 16'h0000;
      wt_q <= 16'h0000;
      sz_q <= 16'h0000;
      sa_q <= 16'h0000;
      of_q <= 16'h0000;
    end else if (wr_c & !busy) begin
      if (paddr == `FMSC_A_CMD) cmd_q <= pwdata[15:0];
      if (paddr == `FMSC_A_WAIT) wt_q <= pwdata[15:0];
      if (paddr == `FMSC_A_RSP_SIZE) sz_q <= pwdata[15:0];
      if (paddr == `FMSC_A_STAT_ADDR) sa_q <= pwdata[15:0];
      if (paddr == `FMSC_A_RSP_OFS) of_q <= pwdata[15:0];
    end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////////////////
  sequence s_hdr;
    mem_we && mem_data == `FMSC_CMD_HEADER && mem_addr == of_q
      ##1 mem_we && mem_data == (is_master ? `FMSC_ROLE_MASTER : `FMSC_ROLE_SLAVE);
  endsequence
  // One idle cycle separates the last reply word from the status word
  sequence s_clr(ok);
    mem_we && mem_data == `FMSC_CMD_CLEAR ##1 mem_we && mem_data == ok
      ##1 !mem_we ##1 mem_we && mem_is_status;
  endsequence
  a_ready_after_setup: assert property (psel && !penable && ce |=> pready)
    else $error("pready missing after setup");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_header_echo_role: assert property (hdr |-> ##2 s_hdr)
    else $error("header reply start wrong");
  a_clear_reply: assert property (clr |-> ##2 s_clr(sz_q <= 16'h0002 ? 16'h0001 : 16'h0000))
    else $error("clear reply wrong");
  a_word_step: assert property (mem_we && !mem_is_status && $past(mem_we) && !$past(mem_is_status)
    |-> mem_addr == $past(mem_addr) + 16'h0001)
    else $error("reply address not consecutive");
  a_status_addr: assert property (mem_we && mem_is_status |-> mem_addr == sa_q + 16'h0001)
    else $error("status word address wrong");
  a_busy_end: assert property ($fell(busy) |-> mem_we && mem_is_status)
    else $error("busy fell without status write");
  a_idle_quiet: assert property (!busy |-> !mem_we || mem_is_status)
    else $error("reply word written while idle");
endmodule // fmsc_cmd_props
bind fmsc_cmd fmsc_cmd_props u_props (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .is_master(is_master), .mem_we(mem_we), .mem_is_status(mem_is_status),
  .mem_addr(mem_addr), .mem_data(mem_data), .busy(busy));

// ---- testbench/fmsc_cmd_tb.sv ----
// Self-checking bench for the statistics command handler
`include "fmsc_defs.vh"
module fmsc_cmd_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam [7:0] MAJ = 8'h03;
  localparam [7:0] MIN = 8'h07;
  logic        pclk = 1'b0, presetn = 1'b0, ce = 1'b1, is_master = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        err_report = 1'b0, err_by_master = 1'b0;
  logic [7:0]  paddr = 8'h00, err_code = 8'h00;
  logic [7:0]  global_state = 8'hA5, shared_memory_state = 8'h5A;
  logic [31:0] pwdata = 32'h0, rd_q;
  logic [9:0]  evt_pin = 10'h000;
  logic [6:0]  err_station = 7'h00;
  logic [15:0] slaves_detected = 16'h0003, slaves_set_up = 16'h0004;
  logic [15:0] slaves_exchanging = 16'h0002, exchange_time_ms = 16'h0123;
  logic [31:0] prdata;
  logic        pready, pslverr, mem_we, mem_is_status, busy, er_q;
  logic [15:0] mem_type, mem_addr, mem_data;
  int          n_errors = 0, check_count = 0;
  always #10 pclk = ~pclk;
  fmsc_cmd #(.FW_MAJOR(MAJ), .FW_MINOR(MIN)) dut (.pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .evt_pin(evt_pin),
    .is_master(is_master), .global_state(global_state),
    .shared_memory_state(shared_memory_state), .err_report(err_report),
    .err_by_master(err_by_master), .err_station(err_station), .err_code(err_code),
    .slaves_detected(slaves_detected), .slaves_set_up(slaves_set_up),
    .slaves_exchanging(slaves_exchanging), .exchange_time_ms(exchange_time_ms),
    .mem_we(mem_we), .mem_is_status(mem_is_status), .mem_type(mem_type),
    .mem_addr(mem_addr), .mem_data(mem_data), .busy(busy));
  fmsc_mem_model u_mem (.pclk(pclk), .mem_we(mem_we), .mem_type(mem_type),
    .mem_addr(mem_addr), .mem_data(mem_data));
  ////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("Checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One idle cycle after each transfer keeps psel from being set twice per step
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    int i;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (pready !== 1'b1) begin
      n_errors++;
      test_done();
    end
    rd_q = prdata;
    er_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic mw(int a, logic [15:0] e);
    chk($sformatf("mem %0d", a), {16'h0000, e}, {16'h0000, u_mem.mem[a[15:0]]});
  endtask
  task automatic run(logic [15:0] cmd, logic [15:0] sz, logic [15:0] ofs);
    int i;
    apb(1'b1, `FMSC_A_LEN, 32'h00000004);
    apb(1'b1, `FMSC_A_WAIT, 32'h00000000);
    apb(1'b1, `FMSC_A_STAT_TYPE, 32'h00000008);
    apb(1'b1, `FMSC_A_STAT_ADDR, 32'h00000009);
    apb(1'b1, `FMSC_A_CMD, {16'h0000, cmd});
    // Reply type differs from status type so a swap between them shows
    apb(1'b1, `FMSC_A_RSP_TYPE, 32'h00000010);
    apb(1'b1, `FMSC_A_RSP_OFS, {16'h0000, ofs});
    apb(1'b1, `FMSC_A_RSP_SIZE, {16'h0000, sz});
    apb(1'b1, `FMSC_A_CTRL, 32'h00000001);
    i = 0;
    do begin
      apb(1'b0, `FMSC_A_STATUS, 32'h0);
      i++;
    end while (rd_q[1] !== 1'b1 && i < 40);
    chk("done", 32'h00000002, {30'h0, rd_q[1:0]});
    apb(1'b1, `FMSC_A_CTRL, 32'h00000002);
  endtask
  task automatic fault(logic by_m, logic [6:0] st, logic [7:0] code);
    err_by_master <= by_m;
    err_station <= st;
    err_code <= code;
    err_report <= 1'b1;
    @(posedge pclk);
    err_report <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `FMSC_A_STATUS, 32'h0);
    chk("status reset", 32'h0, rd_q);
    apb(1'b0, 8'h28, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, er_q});
    apb(1'b1, 8'h40, 32'h0000FFFF);
    chk("reply write err", 32'h1, {31'h0, er_q});
    // Pin b pulses b+1 times
    for (int k = 0; k < 10; k++) begin
      evt_pin <= 10'h3FF << k;
      repeat (3) @(posedge pclk);
      evt_pin <= 10'h000;
      repeat (3) @(posedge pclk);
    end
    fault(1'b0, 7'h7D, 8'h3C);
    repeat (8) @(posedge pclk);
    run(`FMSC_CMD_HEADER, 16'h0014, 16'h00FA);
    mw(250, 16'h0005);
    mw(251, 16'h0002);
    mw(252, {MAJ, MIN});
    mw(253, 16'h5AA5);
    mw(254, 16'h3C7D);
    for (int n = 0; n < 10; n++)
      mw(255 + n, n[15:0] + 16'h0001);
    mw(265, 16'h0003);
    mw(266, 16'h0004);
    mw(267, 16'h0002);
    mw(268, 16'h0123);
    mw(10, `FMSC_ST_OK);
    chk("reply type", 32'h00000010, {16'h0000, u_mem.typ[16'h00FA]});
    chk("status type", 32'h00000008, {16'h0000, u_mem.typ[16'h000A]});
    apb(1'b0, 8'h48, 32'h0);
    chk("reply reg 3", {16'h0000, MAJ, MIN}, rd_q);
    run(`FMSC_CMD_CLEAR, 16'h0003, 16'h012C);
    mw(300, 16'h0006);
    mw(301, 16'h0000);
    mw(10, `FMSC_ST_FAIL);
    is_master <= 1'b0;
    global_state <= 8'h3C;
    shared_memory_state <= 8'hC3;
    slaves_detected <= 16'h0011;
    slaves_set_up <= 16'h0022;
    slaves_exchanging <= 16'h0033;
    exchange_time_ms <= 16'h0044;
    fault(1'b1, 7'h00, 8'h11);
    run(`FMSC_CMD_CLEAR, 16'h0002, 16'h012C);
    mw(301, 16'h0001);
    mw(10, `FMSC_ST_OK);
    run(`FMSC_CMD_HEADER, 16'h0014, 16'h0190);
    mw(401, 16'h0001);
    mw(403, 16'hC33C);
    mw(404, 16'h11FF);
    for (int n = 0; n < 10; n++)
      mw(405 + n, 16'h0000);
    mw(415, 16'h0011);
    mw(418, 16'h0044);
    run(`FMSC_CMD_HEADER, 16'h0013, 16'h01F4);
    mw(10, `FMSC_ST_FAIL);
    test_done();
  end
endmodule // fmsc_cmd_tb

// ---- testbench/fmsc_mem_model.sv ----
// Host memory model that keeps the last reply or status word written to each address
module fmsc_mem_model (
  input wire        pclk,
  input wire        mem_we,
  input wire [15:0] mem_type,
  input wire [15:0] mem_addr,
  input wire [15:0] mem_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem [0:65535];
  logic [15:0] typ [0:65535];
  // Unwritten places read as unknown, so a missing word never matches
  always @(posedge pclk)
    if (mem_we) begin
      mem[mem_addr] <= mem_data;
      typ[mem_addr] <= mem_type;
    end
endmodule // fmsc_mem_model
